/* File: logic/cam_block.sv */
// Content-addressable memory block: 32 entries of 32 bits with per-bit
// don't-care, one-cycle search, encoded or two-cycle unencoded results.
// Assumes search and write requests come from fabric logic on ref_clk.
//
// How it works
// - 32 entries of 32 bits, searched together
// - Don't-care bits never block a match
// - Encoded mode gives the matching entry address
// - Unencoded mode: 16 lines over two cycles
// - Duplicates flagged; encoded answer then unreliable
// - Preload at configuration or run-time writes
// - Write takes two cycles, three with don't-cares
`timescale 1ns/1ps

module cam_block import cam_pkg::*; #(
  parameter logic [CAM_WORDS*CAM_WIDTH-1:0] INIT_DATA = '0,  // Preloaded contents
  parameter logic [CAM_WORDS*CAM_WIDTH-1:0] INIT_CARE = '1   // Preloaded compare masks
) (
  input  wire logic        ref_clk,      // Block clock
  input  wire logic        rst_b,        // Asynchronous reset, active low
  input  wire cam_search_t search,       // Search request
  input  wire cam_write_t  write,        // Write request
  output logic             search_ready, // Search may be taken this cycle
  output cam_result_t      result,       // Search result
  output logic             write_busy,   // Write in progress
  output logic             write_done    // Write committed, one-cycle pulse
);

  // Write sequence states
  // Two steps for a plain write, a third only when some bit is don't-care
  typedef enum logic [1:0] {
    CAM_WR_IDLE,                         // Waiting for a request
    CAM_WR_DATA,                         // Second cycle: contents commit
    CAM_WR_MASK                          // Third cycle: don't-care mask commits
  } cam_wr_state_t;

  // Storage
  // Kept as flops rather than a RAM: every entry feeds its own comparator
  // each cycle, which a RAM with one read port could not do
  logic [CAM_WIDTH-1:0]  cam_data [CAM_WORDS];      // Entry contents
  logic [CAM_WIDTH-1:0]  cam_care [CAM_WORDS];      // 1 = bit compared
  logic [CAM_WIDTH-1:0]  next_cam_data [CAM_WORDS];
  logic [CAM_WIDTH-1:0]  next_cam_care [CAM_WORDS];

  // Write sequencer
  cam_wr_state_t         wr_state;                  // Current write step
  cam_wr_state_t         next_wr_state;
  logic [CAM_ADDR_W-1:0] wr_addr;                   // Latched entry
  logic [CAM_WIDTH-1:0]  wr_data;                   // Latched contents
  logic [CAM_WIDTH-1:0]  wr_care;                   // Latched mask
  logic [CAM_ADDR_W-1:0] next_wr_addr;
  logic [CAM_WIDTH-1:0]  next_wr_data;
  logic [CAM_WIDTH-1:0]  next_wr_care;
  logic                  next_write_busy;
  logic                  next_write_done;

  // Search path
  logic [CAM_WORDS-1:0]  match;                     // Live match vector
  logic [CAM_LINES-1:0]  hi_lines;                  // Held upper half for phase two
  logic                  pending;                   // Upper half still to show
  logic [CAM_LINES-1:0]  next_hi_lines;
  logic                  next_pending;
  logic                  next_search_ready;
  cam_result_t           next_result;

  // Lowest matching entry; the lowest wins so duplicates give a stable answer
  // Limitation: with duplicates only the lowest hit is named; fabric that may
  // hold duplicates should read the unencoded lines or watch the multi flag
  function automatic logic [CAM_ADDR_W-1:0] cam_first(input logic [CAM_WORDS-1:0] vec);
    logic [CAM_ADDR_W-1:0] idx;
    idx = CAM_ADDR_RST;
    for (int i = CAM_WORDS - 1; i >= 0; i--) begin
      if (vec[i]) begin
        idx = CAM_ADDR_W'(i);
      end
    end
    return idx;
  endfunction

  // Parallel compare of every entry
  // One comparator per entry, all in the same cycle; a search therefore sees
  // storage as it stood before the taking edge, never a write landing on it
  genvar g;
  generate
    for (g = 0; g < CAM_WORDS; g++) begin : gen_cmp
      // Masked-off bits drop out of the compare
      assign match[g] = ~|((cam_data[g] ^ search.key) & cam_care[g]);
    end
  endgenerate

  // Write sequencing and storage next values
  // The request is latched on the taking edge, so the writer may change
  // address and data afterwards; only valid has to stay up
  always_comb begin
    next_cam_data   = cam_data;
    next_cam_care   = cam_care;
    next_wr_state   = wr_state;
    next_wr_addr    = wr_addr;
    next_wr_data    = wr_data;
    next_wr_care    = wr_care;
    next_write_done = 1'b0;
    unique case (wr_state)
      CAM_WR_IDLE: begin
        // First cycle: latch the request
        if (write.valid) begin
          next_wr_addr  = write.addr;
          next_wr_data  = write.data;
          next_wr_care  = write.care;
          next_wr_state = CAM_WR_DATA;
        end
      end
      CAM_WR_DATA: begin
        // Dropping the request early abandons it; nothing is committed
        if (!write.valid) begin
          next_wr_state = CAM_WR_IDLE;
        end else if (wr_care == CAM_ALL_CARE) begin
          // Plain write finishes in its second cycle
          next_cam_data[wr_addr] = wr_data;
          next_cam_care[wr_addr] = CAM_ALL_CARE;
          next_write_done        = 1'b1;
          next_wr_state          = CAM_WR_IDLE;
        end else begin
          // Contents now; the mask takes a third cycle
          // Hazard: until the mask lands the entry compares every bit, so a
          // search in between may miss a word that matches once masked
          next_cam_data[wr_addr] = wr_data;
          next_cam_care[wr_addr] = CAM_ALL_CARE;
          next_wr_state          = CAM_WR_MASK;
        end
      end
      CAM_WR_MASK: begin
        // Mask lands only if the writer still holds the request
        if (write.valid) begin
          next_cam_care[wr_addr] = wr_care;
          next_write_done        = 1'b1;
        end
        next_wr_state = CAM_WR_IDLE;
      end
    endcase
    next_write_busy = (next_wr_state != CAM_WR_IDLE);
  end

  // Storage and write registers; reset loads the preload image
  // Trade-off: reset fans out to the whole array, but it gives a known
  // image at every reset without a separate load path
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < CAM_WORDS; i++) begin
        cam_data[i] <= INIT_DATA[i*CAM_WIDTH +: CAM_WIDTH];
        cam_care[i] <= INIT_CARE[i*CAM_WIDTH +: CAM_WIDTH];
      end
      wr_state   <= CAM_WR_IDLE;
      wr_addr    <= CAM_ADDR_RST;
      wr_data    <= '0;
      wr_care    <= CAM_ALL_CARE;
      write_busy <= 1'b0;
      write_done <= 1'b0;
    end else begin
      cam_data   <= next_cam_data;
      cam_care   <= next_cam_care;
      wr_state   <= next_wr_state;
      wr_addr    <= next_wr_addr;
      wr_data    <= next_wr_data;
      wr_care    <= next_wr_care;
      write_busy <= next_write_busy;
      write_done <= next_write_done;
    end
  end

  // Search result next values
  // The upper half is parked at the taking edge so that a write landing in
  // between cannot change what the second cycle reports
  always_comb begin
    next_result   = '0;
    next_hi_lines = hi_lines;
    next_pending  = 1'b0;
    if (pending) begin
      // Second unencoded cycle: entries 16 to 31
      next_result.valid     = 1'b1;
      next_result.unencoded = 1'b1;
      next_result.phase     = CAM_PHASE_HIGH;
      next_result.lines     = hi_lines;
    end else if (search.valid) begin
      next_result.valid     = 1'b1;
      next_result.unencoded = search.unencoded;
      next_result.found     = |match;
      // Several hits make the encoded address untrustworthy
      // Subtracting one clears the lowest hit; anything left is a second hit
      next_result.multi     = (match & (match - CAM_WORDS'(1))) != '0;
      if (search.unencoded) begin
        // First unencoded cycle: entries 0 to 15
        next_result.phase = CAM_PHASE_LOW;
        next_result.lines = match[CAM_LINES-1:0];
        next_hi_lines     = match[CAM_WORDS-1:CAM_LINES];
        next_pending      = 1'b1;
      end else begin
        // Encoded address of the matching entry
        next_result.addr = cam_first(match);
      end
    end
    // The bus is busy with the upper half, so hold off a new search
    next_search_ready = !next_pending;
  end

  // Search result registers
  // Every output leaves straight from a flop, so the fabric sees clock-to-out
  // only; the price is one cycle of search latency
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      result       <= '0;
      hi_lines     <= CAM_LINES_RST;
      pending      <= 1'b0;
      search_ready <= 1'b1;
    end else begin
      result       <= next_result;
      hi_lines     <= next_hi_lines;
      pending      <= next_pending;
      search_ready <= next_search_ready;
    end
  end

endmodule

/* File: logic/cam_pkg.sv */
// Package for the content-addressable memory block: sizes, reset values,
// write timing and the structs that carry search, write and result groups.
// Assumes every user of it runs on the single block clock.
package cam_pkg;

  // Array shape
  localparam int CAM_WORDS  = 32;                // Entries held
  localparam int CAM_WIDTH  = 32;                // Bits per entry and per search key
  localparam int CAM_ADDR_W = 5;                 // Bits of an entry address
  localparam int CAM_LINES  = 16;                // Width of the unencoded result bus

  // Run-time write timing, in clock cycles from the taking edge
  localparam int CAM_WR_CYCLES    = 2;           // Plain write
  localparam int CAM_WR_CYCLES_DC = 3;           // Write carrying don't-care bits

  // Values after reset
  localparam logic [CAM_WIDTH-1:0]  CAM_ALL_CARE  = 32'hFFFF_FFFF; // Every bit compared
  localparam logic [CAM_LINES-1:0]  CAM_LINES_RST = 16'h0000;      // Result lines idle
  localparam logic [CAM_ADDR_W-1:0] CAM_ADDR_RST  = 5'h00;         // Encoded address idle

  // Unencoded result phases
  localparam logic CAM_PHASE_LOW  = 1'b0;        // Entries 0 to 15
  localparam logic CAM_PHASE_HIGH = 1'b1;        // Entries 16 to 31

  // Search request from the fabric
  typedef struct packed {
    logic                 valid;                 // Search this cycle
    logic                 unencoded;             // 1: per-entry match lines, 0: encoded address
    logic [CAM_WIDTH-1:0] key;                   // Pattern to look for
  } cam_search_t;

  // Write request from the fabric
  typedef struct packed {
    logic                  valid;                // Held high for the whole write
    logic [CAM_ADDR_W-1:0] addr;                 // Entry to write
    logic [CAM_WIDTH-1:0]  data;                 // New contents
    logic [CAM_WIDTH-1:0]  care;                 // 0 marks a don't-care bit
  } cam_write_t;

  // Search result to the fabric
  typedef struct packed {
    logic                  valid;                // Result present this cycle
    logic                  unencoded;            // Form of this result
    logic                  phase;                // Unencoded half shown
    logic                  found;                // At least one entry matched
    logic                  multi;                // More than one entry matched
    logic [CAM_ADDR_W-1:0] addr;                 // Encoded match address
    logic [CAM_LINES-1:0]  lines;                // Per-entry match lines of this half
  } cam_result_t;

endpackage

/* File: test/cam_assertions.sv */
// Checker for cam_block: search latency, result halves, write timing.
// Assumes it is bound to cam_block and sees only that module's ports.
`timescale 1ns/1ps
module cam_assertions import cam_pkg::*; (
  input wire logic        ref_clk,      // Block clock
  input wire logic        rst_b,        // Reset, active low
  input wire cam_search_t search,       // Search request
  input wire cam_write_t  write,        // Write request
  input wire logic        search_ready, // Search may be taken
  input wire cam_result_t result,       // Search result
  input wire logic        write_busy,   // Write in progress
  input wire logic        write_done    // Write committed
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Takes of each request kind
  sequence s_enc; search.valid && search_ready && !search.unencoded; endsequence
  sequence s_unc; search.valid && search_ready && search.unencoded; endsequence
  sequence s_wrp; write.valid && !write_busy && write.care == CAM_ALL_CARE; endsequence
  sequence s_wrd; write.valid && !write_busy && write.care != CAM_ALL_CARE; endsequence
  // Low half first, ready withheld for it
  sequence s_halves;
    result.valid && result.unencoded && result.phase == CAM_PHASE_LOW && !search_ready
      ##1 result.valid && result.phase == CAM_PHASE_HIGH && search_ready;
  endsequence
  AST_ENC_LAT: assert property (s_enc |=> result.valid && !result.unencoded) else $error("encoded late");
  AST_UNC_HALVES: assert property (s_unc |=> s_halves) else $error("halves wrong");
  AST_ENC_NOLINES: assert property (result.valid && !result.unencoded |-> result.lines == CAM_LINES_RST)
    else $error("lines in encoded");
  AST_MULTI: assert property (result.multi |-> result.found) else $error("multi without found");
  AST_HIGH_ORDER: assert property (result.valid && result.phase |-> $past(result.phase) == CAM_PHASE_LOW)
    else $error("high half alone");
  AST_WR_PLAIN: assert property (s_wrp ##1 write.valid |=> write_done && !write_busy) else $error("plain write");
  AST_WR_DC: assert property (s_wrd ##1 write.valid [*2] |=> write_done) else $error("masked write");
  AST_WR_DC_WAIT: assert property (s_wrd |=> write_busy && !write_done ##1 !write_done) else $error("early done");
  AST_DONE_PULSE: assert property (write_done |=> !write_done) else $error("done too long");
endmodule
bind cam_block cam_assertions u_chk (.ref_clk, .rst_b, .search, .write, .search_ready, .result, .write_busy,
  .write_done);

/* File: test/cam_fabric_model.sv */
// Fabric user logic: issues search and write requests for the bench.
// Assumes its tasks are called just after a rising edge of ref_clk.
`timescale 1ns/1ps
module cam_fabric_model import cam_pkg::*; (
  input  wire logic  ref_clk, // Block clock
  output cam_search_t search,  // Search request
  output cam_write_t  write    // Write request
);
  initial begin
    search = '0;
    write = '0;
  end
  // One search; released lines flip so a stale key never passes
  task automatic find(logic [31:0] key, logic unc);
    search = '{valid: 1'b1, unencoded: unc, key: key};
    @(posedge ref_clk);
    #1 search = '{valid: 1'b0, unencoded: ~unc, key: ~key};
  endtask
  // Write held for hold edges; a short hold aborts on purpose
  task automatic put(logic [4:0] a, logic [31:0] d, logic [31:0] c, int hold);
    write = '{valid: 1'b1, addr: a, data: d, care: c};
    repeat (hold) @(posedge ref_clk);
    #1 write = '{valid: 1'b0, addr: ~a, data: ~d, care: ~c};
  endtask
endmodule

/* File: test/testbench.sv */
// Self-checking bench for cam_block: preload, corner and random traffic.
// Assumes cam_fabric_model drives requests; the bench models the array.
`timescale 1ns/1ps
module testbench import cam_pkg::*;;
  // Preload image: entry i holds 5A00_0000 plus i
  function automatic logic [CAM_WORDS*CAM_WIDTH-1:0] img();
    for (int i = 0; i < CAM_WORDS; i++) img[i*CAM_WIDTH+:CAM_WIDTH] = 32'h5A00_0000 + i;
  endfunction
  localparam logic [CAM_WORDS*CAM_WIDTH-1:0] IMG = img();
  logic        ref_clk = 1'b0;       // Block clock
  logic        rst_b = 1'b0;         // Reset, active low
  cam_search_t search;               // From the fabric model
  cam_write_t  write;                // From the fabric model
  cam_result_t result;               // Search result
  logic        search_ready, write_busy, write_done;
  logic [31:0] ref_data [CAM_WORDS]; // Expected contents
  logic [31:0] ref_care [CAM_WORDS]; // Expected compare masks
  logic [31:0] seed = 32'h0000_000E; // Xorshift state
  logic [31:0] r, c;                 // Random draws
  int          fails = 0;
  int          check_count = 0;
  always #20 ref_clk = ~ref_clk;
  cam_block #(.INIT_DATA(IMG), .INIT_CARE({CAM_WORDS*CAM_WIDTH{1'b1}})) uut (.ref_clk(ref_clk), .rst_b(rst_b),
    .search(search), .write(write), .search_ready(search_ready), .result(result), .write_busy(write_busy),
    .write_done(write_done));
  cam_fabric_model fab (.ref_clk(ref_clk), .search(search), .write(write));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Match vector; masked bits never block a match
  function automatic logic [31:0] mv(logic [31:0] key);
    for (int i = 0; i < CAM_WORDS; i++) mv[i] = ((ref_data[i] ^ key) & ref_care[i]) == 32'h0000_0000;
  endfunction
  // Lowest matching entry, zero when none
  function automatic logic [4:0] low(logic [31:0] m);
    low = CAM_ADDR_RST;
    for (int i = CAM_WORDS - 1; i >= 0; i--) if (m[i]) low = 5'(i);
  endfunction
  task automatic cmp(string name, logic [63:0] exp, logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic srch(logic [31:0] key, logic unc);
    logic [31:0] m;
    m = mv(key);
    fab.find(key, unc);
    if (unc) begin
      cmp("low half", {4'b1100, m[15:0]},
        {result.valid, result.unencoded, result.phase, search_ready, result.lines});
      @(posedge ref_clk);
      #1 cmp("high half", {4'b1111, m[31:16]},
        {result.valid, result.unencoded, result.phase, search_ready, result.lines});
    end else begin
      cmp("encoded", {3'b101, |m, $countones(m) > 1, low(m), CAM_LINES_RST}, {result.valid, result.unencoded,
        search_ready, result.found, result.multi, result.addr, result.lines});
    end
  endtask
  // Two-edge hold of a masked write leaves data with every bit compared; one edge writes nothing
  task automatic wr(logic [4:0] a, logic [31:0] d, logic [31:0] k, int hold);
    logic full;
    full = hold == ((k == CAM_ALL_CARE) ? CAM_WR_CYCLES : CAM_WR_CYCLES_DC);
    fab.put(a, d, k, hold);
    cmp("write_done", 64'(full), 64'(write_done));
    cmp("write_busy", 64'(!full), 64'(write_busy));
    if (hold >= CAM_WR_CYCLES) ref_data[a] = d;
    if (hold >= CAM_WR_CYCLES) ref_care[a] = full ? k : CAM_ALL_CARE;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    for (int i = 0; i < CAM_WORDS; i++) ref_data[i] = IMG[i*CAM_WIDTH+:CAM_WIDTH];
    for (int i = 0; i < CAM_WORDS; i++) ref_care[i] = CAM_ALL_CARE;
    repeat (8) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    srch(32'h5A00_0011, 1'b0);
    srch(32'h5A00_001F, 1'b1);
    $display("preload test done");
    wr(5'h03, 32'h0BAD_F00D, CAM_ALL_CARE, 2);
    wr(5'h14, 32'h0BAD_F00D, CAM_ALL_CARE, 2);
    srch(32'h0BAD_F00D, 1'b0);
    srch(32'h0BAD_F00D, 1'b1);
    wr(5'h14, 32'h1234_5678, 32'hFFFF_0000, 3);
    srch(32'h1234_ABCD, 1'b0);
    wr(5'h03, 32'h7777_0000, CAM_ALL_CARE, 1);
    srch(32'h0BAD_F00D, 1'b1);
    wr(5'h05, 32'h4444_0000, 32'h0000_FFFF, 2);
    srch(32'h4444_1111, 1'b0);
    $display("corner test done");
    for (int n = 0; n < 60; n++) begin
      r = xs();
      c = r[0] ? CAM_ALL_CARE : xs();
      wr(r[5:1], xs(), c, 1 + int'(r[7:6]) % ((c == CAM_ALL_CARE) ? 2 : 3));
      r = xs();
      c = xs();
      srch(r[1] ? c : ref_data[r[6:2]] ^ (c & ~ref_care[r[6:2]]), r[0]);
    end
    $display("random test done");
    conclude();
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    fails++;
    conclude();
  end
endmodule
